// >>> hdl/eedac_ctrl.sv
// Instruction decoder, word store and converter control
`include "eedac_regs.svh"
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] Sample input on rise, drive output on fall
// [RULE2] Frame: opcode, address, two data bytes
// [RULE3] Decode seven user instructions
// [RULE4] Output released except read data, ready/busy
// [RULE5] Writing disabled after power-up
// [RULE6] Disabled writes leave memory unchanged
// [RULE7] Write enable holds until write disable
// [RULE8] Reads ignore write enable state
// [RULE9] Power-down: outputs released, converter standby
// [RULE10] Power-down at power-up until autoload done
// [RULE11] Power-down enter/exit instructions after autoload
// [RULE12] Converter values kept across power-down
// [RULE13] Word 0: high byte ch0, low ch1
// [RULE14] 16-bit words, rest general purpose
// [RULE15] Normal-mode word 0 write updates outputs
// [RULE16] Power-down word 0 write keeps outputs released
// [RULE17] Load instruction copies addressed word to outputs
// [RULE18] Load instruction ignored in power-down
// [RULE19] Autoload starts at first select fall
// [RULE20] Outputs set within 2 ms
// [RULE21] Autoload ignores clock and data in
// [RULE22] Autoload once; first select period unused
// [RULE23] After bit 32 program, show ready/busy
// [RULE24] Read data from 17th fall, MSB first
// [RULE25] Sequential read wraps to address zero
// [RULE26] Host deselects between instructions
// [RULE27] Early deselect abandons the instruction
// [RULE28] Unknown opcodes ignored
module eedac_ctrl #(
  parameter int ADDR_W = 7,
  parameter int AUTOLOAD_CYCLES = `AUTOLOAD_CYC,
  parameter int PROG_CYCLES = `PROG_CYC
) (
  input wire logic core_clk_i, // 40 MHz core clock
  input wire logic resetn_i, // Power-on reset
  input wire logic chip_select_n_i, // Chip select pin
  input wire logic serial_clock_in_i, // Serial clock pin
  input wire logic serial_in_i, // Serial data pin
  output logic serial_out_o, // Serial data out
  output logic serial_out_oe_o, // Serial out enable
  output logic [7:0] analog_out_ch0_o, // Channel 0 code
  output logic [7:0] analog_out_ch1_o, // Channel 1 code
  output logic analog_out_ch0_oe_o, // Channel 0 active
  output logic analog_out_ch1_oe_o, // Channel 1 active
  output logic powered_down_o, // Converter standby
  output logic write_enabled_o // Write enable state
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int ACW = 16;

  logic [2:0] cs_s_q, sk_s_q, di_s_q;
  logic cs_n_q, sk_q, di_q;
  eedac_pkg::state_t st_q;
  logic [15:0] mem_q [DEPTH];
  logic [5:0] bit_cnt_q;
  logic [7:0] op_q, addr_q;
  logic [15:0] sh_q, rd_q;
  logic [3:0] rd_bit_q;
  logic wen_q, pd_q;
  logic [7:0] ch0_q, ch1_q;
  logic [ACW-1:0] cnt_q;
  logic [15:0] pend_data_q;
  logic pend_wr_q;
  logic do_q, oe_q;

  // Three-stage sync, change counted once stages 2 and 3 agree
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s_q <= 3'h7;
      sk_s_q <= 3'h0;
      di_s_q <= 3'h0;
      cs_n_q <= 1'b1;
      sk_q <= 1'b0;
      di_q <= 1'b0;
    end else begin
      cs_s_q <= {cs_s_q[1:0], chip_select_n_i};
      sk_s_q <= {sk_s_q[1:0], serial_clock_in_i};
      di_s_q <= {di_s_q[1:0], serial_in_i};
      if (cs_s_q[1] == cs_s_q[2]) cs_n_q <= cs_s_q[2];
      if (sk_s_q[1] == sk_s_q[2]) sk_q <= sk_s_q[2];
      if (di_s_q[1] == di_s_q[2]) di_q <= di_s_q[2];
    end
  end

  wire sk_now = (sk_s_q[1] == sk_s_q[2]) ? sk_s_q[2] : sk_q;
  wire cs_now = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_n_q;
  wire sk_rise = sk_now & ~sk_q; // [RULE1]
  wire sk_fall = ~sk_now & sk_q; // [RULE1]
  wire cs_fall = ~cs_now & cs_n_q;
  wire cs_high = cs_now;
  wire [7:0] op_now = {op_q[6:0], di_q};
  wire [ADDR_W-1:0] addr_now = ADDR_W'({addr_q[6:0], di_q});
  wire [ADDR_W-1:0] waddr = ADDR_W'(addr_q);
  wire [15:0] wdata = {sh_q[14:0], di_q};
  wire [ADDR_W-1:0] rd_next = waddr + ADDR_W'(1); // [RULE25]

  function automatic logic known_op(input logic [7:0] op);
    known_op = (op == `OP_READ) || (op == `OP_WRITE) || (op == `OP_WRITE_ENABLE_CMD) || (op == `OP_WRITE_DISABLE_CMD)
      || (op == `OP_POWERDOWN_ENTER_CMD) || (op == `OP_POWERDOWN_EXIT_CMD) || (op == `OP_CALL); // [RULE3] [RULE28]
  endfunction : known_op

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= eedac_pkg::ST_BOOT;
      bit_cnt_q <= 6'h00;
      op_q <= 8'h00;
      addr_q <= 8'h00;
      sh_q <= 16'h0000;
      rd_q <= 16'h0000;
      rd_bit_q <= 4'h0;
      wen_q <= 1'b0; // [RULE5]
      pd_q <= 1'b1; // [RULE10]
      ch0_q <= 8'h00;
      ch1_q <= 8'h00;
      cnt_q <= '0;
      pend_data_q <= 16'h0000;
      pend_wr_q <= 1'b0;
      do_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      case (st_q)
        eedac_pkg::ST_BOOT: begin
          if (cs_fall) begin // [RULE19]
            st_q <= eedac_pkg::ST_LOAD;
            cnt_q <= '0;
          end
        end
        eedac_pkg::ST_LOAD: begin
          // Serial pins ignored here [RULE21]
          cnt_q <= cnt_q + ACW'(1);
          if (cnt_q == ACW'(AUTOLOAD_CYCLES - 1)) begin // [RULE20]
            ch0_q <= mem_q[0][15:8]; // [RULE13]
            ch1_q <= mem_q[0][7:0];
            pd_q <= 1'b0; // [RULE10]
            st_q <= eedac_pkg::ST_DONE; // [RULE22]
          end
        end
        eedac_pkg::ST_DONE: begin
          if (cs_high) st_q <= eedac_pkg::ST_IDLE; // [RULE22]
        end
        eedac_pkg::ST_IDLE: begin
          oe_q <= 1'b0; // [RULE4]
          bit_cnt_q <= 6'h00;
          if (!cs_now && cs_n_q) st_q <= eedac_pkg::ST_SHIFT;
        end
        eedac_pkg::ST_SHIFT: begin
          if (cs_high) begin
            st_q <= eedac_pkg::ST_IDLE; // [RULE27]
          end else if (sk_rise) begin // [RULE2]
            bit_cnt_q <= bit_cnt_q + 6'h01;
            if (bit_cnt_q < 6'd8) op_q <= op_now;
            else if (bit_cnt_q < 6'd16) addr_q <= {addr_q[6:0], di_q};
            else sh_q <= wdata;
            if (bit_cnt_q == 6'd7 && !known_op(op_now)) st_q <= eedac_pkg::ST_DONE; // [RULE28]
            if (bit_cnt_q == 6'd15) begin
              if (op_q == `OP_READ) begin
                rd_q <= mem_q[addr_now]; // [RULE8]
                addr_q <= 8'(addr_now);
                rd_bit_q <= 4'hF;
                st_q <= eedac_pkg::ST_READ;
              end else if (op_q == `OP_CALL) begin
                if (!pd_q) begin // [RULE18]
                  ch0_q <= mem_q[addr_now][15:8]; // [RULE17]
                  ch1_q <= mem_q[addr_now][7:0];
                end
                st_q <= eedac_pkg::ST_DONE;
              end
            end
            if (bit_cnt_q == `FRAME_BITS - 6'd1) begin
              st_q <= eedac_pkg::ST_DONE;
              case (op_q)
                `OP_WRITE_ENABLE_CMD: wen_q <= 1'b1; // [RULE7]
                `OP_WRITE_DISABLE_CMD: wen_q <= 1'b0; // [RULE7]
                `OP_POWERDOWN_ENTER_CMD: pd_q <= 1'b1; // [RULE11]
                `OP_POWERDOWN_EXIT_CMD: pd_q <= 1'b0; // [RULE11] [RULE12]
                `OP_WRITE: begin
                  if (waddr == '0 && !pd_q) begin // [RULE15] [RULE16]
                    ch0_q <= wdata[15:8];
                    ch1_q <= wdata[7:0];
                  end
                  pend_wr_q <= wen_q; // [RULE6]
                  pend_data_q <= wdata;
                  cnt_q <= '0;
                  oe_q <= 1'b1; // [RULE23]
                  do_q <= 1'b0;
                  st_q <= eedac_pkg::ST_BUSY;
                end
                default: ;
              endcase
            end
          end
        end
        eedac_pkg::ST_READ: begin
          if (cs_high) begin
            st_q <= eedac_pkg::ST_IDLE;
          end else if (sk_fall) begin // [RULE24]
            if (bit_cnt_q == `READ_START_BIT) begin
              // Fall right after the last address bit keeps the line released
              bit_cnt_q <= bit_cnt_q + 6'h01;
            end else begin
              oe_q <= 1'b1;
              do_q <= rd_q[rd_bit_q];
              rd_bit_q <= rd_bit_q - 4'h1;
              if (rd_bit_q == 4'h0) begin
                rd_q <= mem_q[rd_next]; // [RULE25]
                addr_q <= 8'(rd_next);
              end
            end
          end
        end
        eedac_pkg::ST_BUSY: begin
          cnt_q <= cnt_q + ACW'(1);
          if (cnt_q == ACW'(PROG_CYCLES - 1)) begin
            do_q <= 1'b1; // [RULE23]
            pend_wr_q <= 1'b0;
            st_q <= eedac_pkg::ST_DONE;
          end
          if (cs_high) oe_q <= 1'b0;
        end
        default: st_q <= eedac_pkg::ST_IDLE;
      endcase
      if (st_q == eedac_pkg::ST_DONE && cs_high) oe_q <= 1'b0; // [RULE4]
      if (st_q == eedac_pkg::ST_DONE && !cs_high && oe_q && sk_rise && di_q) oe_q <= 1'b0;
    end
  end

  // Memory update at end of self-timed programming
  wire commit = (st_q == eedac_pkg::ST_BUSY) && (cnt_q == ACW'(PROG_CYCLES - 1)) && pend_wr_q;
  always_ff @(posedge core_clk_i) begin
    if (commit) mem_q[waddr] <= pend_data_q; // [RULE6] [RULE14]
  end

  assign serial_out_o = do_q;
  assign serial_out_oe_o = oe_q; // [RULE4]
  assign analog_out_ch0_o = ch0_q;
  assign analog_out_ch1_o = ch1_q;
  assign analog_out_ch0_oe_o = ~pd_q; // [RULE9]
  assign analog_out_ch1_oe_o = ~pd_q;
  assign powered_down_o = pd_q;
  assign write_enabled_o = wen_q;

  // Frame milestones watched by the checks below
  wire shift_rise = (st_q == eedac_pkg::ST_SHIFT) && !cs_high && sk_rise;
  wire op_end = shift_rise && (bit_cnt_q == 6'd7);
  wire addr_end = shift_rise && (bit_cnt_q == `CALL_BITS - 6'd1);
  wire frame_end = shift_rise && (bit_cnt_q == `FRAME_BITS - 6'd1);

  // Autoload age, held against the 2 ms limit
  localparam int LOAD_LIMIT = (`CORE_HZ / 1000) * `AUTOLOAD_MS;
  logic [16:0] load_cyc_q;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_cyc_q <= 17'h00000;
    end else if (st_q == eedac_pkg::ST_LOAD) begin
      load_cyc_q <= load_cyc_q + 17'h00001;
    end else begin
      load_cyc_q <= 17'h00000;
    end
  end

  // Power-up, autoload and output release
  a_wen_reset: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE5]
    (st_q == eedac_pkg::ST_LOAD) |-> !wen_q) else $error("write enable set before load");
  a_pd_boot: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE10]
    (st_q == eedac_pkg::ST_BOOT) |-> pd_q && !analog_out_ch0_oe_o) else $error("not powered down at boot");
  a_load_end: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE20]
    (st_q == eedac_pkg::ST_LOAD) |-> (load_cyc_q < 17'(LOAD_LIMIT))) else $error("autoload late");
  a_no_drive_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE21]
    (st_q == eedac_pkg::ST_LOAD) |-> !serial_out_oe_o) else $error("driving during autoload");
  a_no_commit_dis: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE6]
    commit |-> $past(pend_wr_q)) else $error("write without enable");
  a_pd_release: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE9]
    pd_q |-> !analog_out_ch0_oe_o && !analog_out_ch1_oe_o) else $error("outputs active in power-down");
  a_pd_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE16]
    pd_q && $stable(pd_q) && st_q != eedac_pkg::ST_LOAD |-> $stable(ch0_q))
    else $error("channel moved in power-down");
  a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE4]
    (st_q == eedac_pkg::ST_IDLE) ##1 (st_q == eedac_pkg::ST_IDLE) |-> !serial_out_oe_o)
    else $error("output driven idle");

  // Instruction effects at opcode, address and frame end, on deselect, at read start and while busy
  a_wdis_keep: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE6]
    frame_end && (op_q == `OP_WRITE) && !wen_q |=> !pend_wr_q) else $error("disabled write armed");
  a_write_enable_cmd_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE7]
    frame_end && (op_q == `OP_WRITE_ENABLE_CMD) |=> wen_q) else $error("write enable not set");
  a_write_disable_cmd_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE7]
    frame_end && (op_q == `OP_WRITE_DISABLE_CMD) |=> !wen_q) else $error("write enable not cleared");
  a_powerdown_enter_cmd_enter: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE11]
    frame_end && (op_q == `OP_POWERDOWN_ENTER_CMD) |=> pd_q) else $error("power-down not entered");
  a_powerdown_exit_cmd_exit: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE11]
    frame_end && (op_q == `OP_POWERDOWN_EXIT_CMD) |=> !pd_q) else $error("power-down not left");
  a_word0_codes: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE15]
    frame_end && (op_q == `OP_WRITE) && (waddr == '0) && !pd_q |=> ({ch0_q, ch1_q} == $past(wdata)))
    else $error("word 0 write did not set codes");
  a_call_pd: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE18]
    addr_end && (op_q == `OP_CALL) && pd_q |=> $stable(ch0_q) && $stable(ch1_q))
    else $error("load ran in power-down");
  a_unknown_op: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE28]
    op_end && !known_op(op_now) |=> (st_q == eedac_pkg::ST_DONE)) else $error("unknown opcode accepted");
  a_abort_keep: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE27]
    (st_q == eedac_pkg::ST_SHIFT) && cs_high |=> $stable(wen_q) && $stable(pd_q) && $stable(ch0_q))
    else $error("cut frame changed state");
  a_read_start: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE24]
    (st_q == eedac_pkg::ST_READ) && (bit_cnt_q == `READ_START_BIT) |-> !serial_out_oe_o)
    else $error("read data driven too early");
  a_busy_low: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE23]
    (st_q == eedac_pkg::ST_BUSY) |-> !serial_out_o) else $error("busy not shown low");
endmodule : eedac_ctrl
`default_nettype wire

// >>> hdl/eedac_pkg.sv
// Types for the serial memory and dual converter control block
package eedac_pkg;
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_LOAD = 3'h1,
    ST_IDLE = 3'h3,
    ST_SHIFT = 3'h2,
    ST_READ = 3'h6,
    ST_BUSY = 3'h7,
    ST_DONE = 3'h5
  } state_t;
endpackage : eedac_pkg

// >>> hdl/eedac_regs.svh
// Constants for the serial memory and dual converter control block
`ifndef EEDAC_REGS_SVH
`define EEDAC_REGS_SVH
`define OP_READ 8'hA8
`define OP_WRITE 8'hA4
`define OP_WRITE_ENABLE_CMD 8'hA1
`define OP_WRITE_DISABLE_CMD 8'hA2
`define OP_POWERDOWN_ENTER_CMD 8'hA3
`define OP_POWERDOWN_EXIT_CMD 8'hA5
`define OP_CALL 8'hA6
`define FRAME_BITS 6'd32
`define READ_START_BIT 6'd16
`define CALL_BITS 6'd16
`define AUTOLOAD_MS 2
`define CORE_HZ 40000000
`define AUTOLOAD_CYC ((`CORE_HZ / 1000) * `AUTOLOAD_MS / 2)
`define PROG_CYC 20000
`endif

// >>> verif/host_port.sv
// Host serial port model for the memory and converter block
`timescale 1ns/100ps
`default_nettype none
module host_port (
  input wire logic core_clk_i, // Pacing clock
  output logic cs_n_o, // Chip select, active low
  output logic sk_o, // Serial clock, idles low
  output logic di_o, // Serial data to device
  input wire logic do_i, // Serial data from device
  input wire logic do_oe_i // Device drives serial data
);
  logic [63:0] rx_q;
  logic ready_ok;
  initial begin
    cs_n_o = 1'b1;
    sk_o = 1'b0;
    di_o = 1'b0;
    rx_q = '0;
    ready_ok = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask : tick
  // Released line read as Z so no stale level passes
  task automatic frame(input logic [31:0] tx, input int n, input bit hold);
    cs_n_o = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      di_o = (i < 32) ? tx[31 - i] : 1'b0;
      tick(4);
      sk_o = 1'b1;
      tick(4);
      rx_q = {rx_q[62:0], do_oe_i ? do_i : 1'bz};
      sk_o = 1'b0;
    end
    if (!hold) release_cs();
  endtask : frame
  // Deselect gap between instructions
  task automatic release_cs();
    tick(4);
    cs_n_o = 1'b1;
    di_o = ~di_o;
    tick(8);
  endtask : release_cs
  // Busy low must precede ready high
  task automatic wait_ready();
    bit low = 0;
    ready_ok = 1'b0;
    for (int i = 0; i < 400 && !ready_ok; i++) begin
      tick(1);
      if (do_oe_i === 1'b1 && do_i === 1'b0) low = 1;
      if (low && do_oe_i === 1'b1 && do_i === 1'b1) ready_ok = 1'b1;
    end
    release_cs();
  endtask : wait_ready
endmodule : host_port
`default_nettype wire

// >>> verif/tb_serial_eeprom_dual_dac_control.sv
// Testbench for the memory and converter control block
`timescale 1ns/100ps
`default_nettype none
`include "eedac_regs.svh"
module tb_serial_eeprom_dual_dac_control;
  logic core_clk_i, resetn_i, cs_n, sk, di, do_w, do_oe, pd, wen, oe0, oe1;
  logic [7:0] ch0, ch1;
  int err_count = 0;
  int total_checks = 0;
  eedac_ctrl #(.ADDR_W(8), .AUTOLOAD_CYCLES(50), .PROG_CYCLES(20)) i_dut (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .chip_select_n_i(cs_n), .serial_clock_in_i(sk), .serial_in_i(di),
    .serial_out_o(do_w), .serial_out_oe_o(do_oe), .analog_out_ch0_o(ch0), .analog_out_ch1_o(ch1),
    .analog_out_ch0_oe_o(oe0), .analog_out_ch1_oe_o(oe1), .powered_down_o(pd), .write_enabled_o(wen));
  host_port i_host (.core_clk_i(core_clk_i), .cs_n_o(cs_n), .sk_o(sk), .di_o(di), .do_i(do_w),
    .do_oe_i(do_oe));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic md(input logic p, input logic w, input logic o);
    chk("mode", {12'h0, p, w, o, o}, {12'h0, pd, wen, oe0, oe1});
  endtask : md
  task automatic cmd(input logic [7:0] op, input logic [7:0] a);
    i_host.frame({op, a, 16'h0000}, 32, 0);
  endtask : cmd
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit en);
    i_host.frame({`OP_WRITE, a, d}, 32, 1);
    chk("wen_state", {15'h0000, en}, {15'h0000, wen});
    i_host.wait_ready();
    chk("ready", 16'h0001, {15'h0, i_host.ready_ok});
    chk("do_oe", 16'h0000, {15'h0, do_oe});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e0, input logic [15:0] e1);
    i_host.frame({`OP_READ, a, 16'h0000}, 49, 0);
    chk("rd_word", e0, i_host.rx_q[31:16]);
    chk("rd_next", e1, i_host.rx_q[15:0]);
  endtask : rd
  // Power cycle, then a first frame that must be swallowed by the autoload
  task automatic pwr();
    resetn_i = 1'b0;
    i_host.tick(10);
    resetn_i = 1'b1;
    md(1'b1, 1'b0, 1'b0);
    cmd(`OP_WRITE_ENABLE_CMD, 8'h00);
    md(1'b0, 1'b0, 1'b1);
    chk("do_boot", 16'hZZZZ, i_host.rx_q[15:0]);
  endtask : pwr
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_count++;
    results();
  end
  initial begin
    pwr();
    cmd(`OP_WRITE_ENABLE_CMD, 8'h00);
    md(1'b0, 1'b1, 1'b1);
    wr(8'h01, 16'h0F1E, 1);
    wr(8'hFF, 16'h9F0E, 1);
    wr(8'h05, 16'hABCD, 1);
    wr(8'h00, 16'h5566, 1);
    cmd(`OP_WRITE_DISABLE_CMD, 8'h00);
    md(1'b0, 1'b0, 1'b1);
    wr(8'h00, 16'h1234, 0);
    chk("codes", 16'h1234, {ch0, ch1});
    wr(8'h05, 16'h0000, 0);
    rd(8'h00, 16'h5566, 16'h0F1E);
    rd(8'hFF, 16'h9F0E, 16'h5566);
    i_host.frame({`OP_CALL, 8'h05, 16'h0000}, 16, 0);
    chk("codes", 16'hABCD, {ch0, ch1});
    $display("done: write and read");
    i_host.frame({8'h55, 24'h000000}, 32, 0);
    i_host.frame({`OP_WRITE_ENABLE_CMD, 24'h000000}, 20, 0);
    md(1'b0, 1'b0, 1'b1);
    chk("codes", 16'hABCD, {ch0, ch1});
    $display("done: refused frames");
    cmd(`OP_POWERDOWN_ENTER_CMD, 8'h00);
    md(1'b1, 1'b0, 1'b0);
    i_host.frame({`OP_CALL, 8'h01, 16'h0000}, 16, 0);
    cmd(`OP_WRITE_ENABLE_CMD, 8'h00);
    wr(8'h00, 16'h7788, 1);
    md(1'b1, 1'b1, 1'b0);
    cmd(`OP_POWERDOWN_EXIT_CMD, 8'h00);
    md(1'b0, 1'b1, 1'b1);
    chk("codes", 16'hABCD, {ch0, ch1});
    rd(8'h00, 16'h7788, 16'h0F1E);
    $display("done: power-down");
    pwr();
    chk("codes", 16'h7788, {ch0, ch1});
    $display("done: autoload");
    results();
  end
endmodule : tb_serial_eeprom_dual_dac_control
`default_nettype wire
